/* File: design/o2_spi_slave.sv */
// Purpose: Serial command and status slave of an exhaust oxygen controller
// Assumes: Host is mode 0 master; measurement core supplies codes and values
// Notes:   Frame is selector byte then low and high data bytes
//
// Overview of operation
// [RULE1] Clock idles low, sample rising, change falling
// [RULE2] All bytes shifted most significant bit first
// [RULE3] Serial clock up to 1.82 MHz supported
// [RULE4] Master frames transfer with chip select low
// [RULE5] First returned byte is the error code
// [RULE6] Selector top bit one means write
// [RULE7] Selector low seven bits index a word
// [RULE8] Index 0 command, 1 oxygen, 2 lambda
// [RULE9] Read returns low byte then high byte
// [RULE10] Master discards returned bytes on writes
// [RULE11] Read data bytes change nothing
// [RULE12] Command upper byte reads as zero
// [RULE13] Master writes reserved command bits as zero
// [RULE14] Bit 0 starts calibration, clears when done
// [RULE15] Bit 5 shows last calibration failed
// [RULE16] Bit 3 stores calibration, clears when done
// [RULE17] Codes 00 normal, 01/41/51 invalid readings
// [RULE18] Codes 14, 15, 52 heater faults, invalid
// [RULE19] Codes 31, 32 supply warnings, still valid
// [RULE20] Invalid readings answer lambda 0, oxygen 8000
// [RULE21] Valid low until sensor ready
// [RULE22] Standby low kills valid, output, heater
// [RULE23] Master polls valid and reads error code
// [RULE24] Master reads values at most every 10ms; the bench host reads back to back, one transfer after another
// [RULE25] Chip select high restarts byte position
// [RULE26] Writes apply only on complete data byte
`timescale 1ns/1ps
module o2_spi_slave (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe_n,
   input wire logic standby_n,
   input wire o2_pkg::byte_t error_code_byte,
   input wire o2_pkg::word_t oxygen_raw,
   input wire o2_pkg::word_t lambda_raw,
   input wire logic cal_done,
   input wire logic cal_ok,
   input wire logic store_done,
   output logic start_cal,
   output logic store_cal,
   output logic valid,
   output logic heater_on,
   output logic analog_zero
);
   import o2_pkg::*;

   // ---------------------------------------------------------------
   // Submodules
   // ---------------------------------------------------------------
   link_if lnk ();

   // [RULE3] Edges found by oversampling at clk
   spi_link_frontend u_front (
      .clk(clk),
      .nrst(nrst),
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe_n(miso_oe_n),
      .lnk(lnk.front)
   );

   standby_valid_ctrl u_standby (
      .clk(clk),
      .nrst(nrst),
      .standby_n(standby_n),
      .error_code_byte(error_code_byte),
      .valid(valid),
      .heater_on(heater_on),
      .analog_zero(analog_zero)
   );

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   frame_phase_t phase_reg, phase_next;
   logic write_req_reg;
   index_t word_idx_reg;
   word_t read_word_reg;
   logic start_flag_reg;
   logic store_flag_reg;
   logic fail_flag_reg;
   logic start_cal_reg;
   logic store_cal_reg;

   // ---------------------------------------------------------------
   // Decoding
   // ---------------------------------------------------------------
   wire sel_done = lnk.byte_done && (phase_reg == PH_SEL);
   wire lo_done = lnk.byte_done && (phase_reg == PH_LO);
   wire hi_done = lnk.byte_done && (phase_reg == PH_HI);
   // [RULE7] Low seven bits pick the word
   wire index_t sel_index = lnk.rx_byte[6:0];
   // [RULE6] Top bit marks a write
   wire sel_write = lnk.rx_byte[BIT_WRITE_REQ];
   // [RULE17] Readings valid only for some codes
   wire readings_valid = readings_ok(error_code_byte);

   // [RULE11] Reads never touch command flags
   // [RULE26] Write only on full low data byte
   wire cmd_write = lo_done && write_req_reg && (word_idx_reg == IDX_COMMAND);
   // [RULE14] Writing one starts calibration
   wire set_start = cmd_write && lnk.rx_byte[BIT_START_CAL];
   // [RULE16] Writing one starts store
   wire set_store = cmd_write && lnk.rx_byte[BIT_STORE_CAL];

   // [RULE12] Upper byte and reserved bits read zero
   wire word_t command_word = {BYTE_ZERO, 2'b00, fail_flag_reg, 1'b0, store_flag_reg, 2'b00, start_flag_reg};

   // [RULE20] Substitute values when readings invalid
   wire word_t oxygen_word = readings_valid ? oxygen_raw : OXYGEN_INVALID;
   wire word_t lambda_word = readings_valid ? lambda_raw : LAMBDA_INVALID;

   // [RULE8] Word map
   wire word_t selected_word = (sel_index == IDX_COMMAND) ? command_word :
                               (sel_index == IDX_OXYGEN) ? oxygen_word :
                               (sel_index == IDX_LAMBDA) ? lambda_word : UNMAPPED_WORD;

   // [RULE5] Error code first, then [RULE9] low and high byte
   assign lnk.tx_byte = (phase_reg == PH_LO) ? read_word_reg[7:0] :
                        (phase_reg == PH_HI) ? read_word_reg[15:8] :
                        (phase_reg == PH_OVER) ? BYTE_ZERO : error_code_byte;

   // ---------------------------------------------------------------
   // Frame phase
   // ---------------------------------------------------------------
   always_comb begin
      phase_next = phase_reg;
      // [RULE25] Deselect returns to selector byte
      if (!lnk.frame_active) begin
         phase_next = PH_IDLE;
      end else begin
         case (phase_reg)
            PH_IDLE: begin
               phase_next = PH_SEL;
            end
            PH_SEL: begin
               if (sel_done) begin
                  phase_next = PH_LO;
               end
            end
            PH_LO: begin
               if (lo_done) begin
                  phase_next = PH_HI;
               end
            end
            PH_HI: begin
               if (hi_done) begin
                  phase_next = PH_OVER;
               end
            end
            PH_OVER: begin
               phase_next = PH_OVER;
            end
            default: begin
               phase_next = PH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_reg <= PH_IDLE;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // ---------------------------------------------------------------
   // Selector capture
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         write_req_reg <= 1'b0;
         word_idx_reg <= IDX_COMMAND;
         read_word_reg <= COMMAND_RESET;
      end else if (sel_done) begin
         write_req_reg <= sel_write;
         word_idx_reg <= sel_index;
         read_word_reg <= selected_word;
      end
   end

   // ---------------------------------------------------------------
   // Command flags, set wins over clear
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         start_flag_reg <= 1'b0;
         store_flag_reg <= 1'b0;
         fail_flag_reg <= 1'b0;
         start_cal_reg <= 1'b0;
         store_cal_reg <= 1'b0;
      end else begin
         start_cal_reg <= set_start;
         store_cal_reg <= set_store;
         // [RULE14] Held until calibration ends
         if (set_start) begin
            start_flag_reg <= 1'b1;
         end else if (cal_done) begin
            start_flag_reg <= 1'b0;
         end
         // [RULE15] Reflects latest attempt
         if (cal_done) begin
            fail_flag_reg <= ~cal_ok;
         end
         // [RULE16] Held until store ends
         if (set_store) begin
            store_flag_reg <= 1'b1;
         end else if (store_done) begin
            store_flag_reg <= 1'b0;
         end
      end
   end

   assign start_cal = start_cal_reg;
   assign store_cal = store_cal_reg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_ec_first: assert property (@(posedge clk) disable iff (!nrst) // [RULE5]
      phase_reg inside {PH_IDLE, PH_SEL} |-> lnk.tx_byte == error_code_byte) else $error("first byte not error code");

   a_write_decode: assert property (@(posedge clk) disable iff (!nrst)
      sel_done |=> write_req_reg == $past(sel_write)) else $error("write bit not captured"); // [RULE6]

   a_index_latch: assert property (@(posedge clk) disable iff (!nrst)
      sel_done |=> word_idx_reg == $past(sel_index)) else $error("word index not captured"); // [RULE7]

   a_map_oxygen: assert property (@(posedge clk) disable iff (!nrst)
      sel_done && sel_index == IDX_OXYGEN && readings_valid |=> read_word_reg == $past(oxygen_raw))
      else $error("oxygen word not selected"); // [RULE8]

   a_map_lambda: assert property (@(posedge clk) disable iff (!nrst)
      sel_done && sel_index == IDX_LAMBDA && readings_valid |=> read_word_reg == $past(lambda_raw))
      else $error("lambda word not selected"); // [RULE8]

   a_low_high: assert property (@(posedge clk) disable iff (!nrst) // [RULE9]
      sel_done && lnk.frame_active |=> phase_reg == PH_LO && lnk.tx_byte == read_word_reg[7:0])
      else $error("low data byte not offered");

   a_high_after_low: assert property (@(posedge clk) disable iff (!nrst) // [RULE9]
      lo_done && lnk.frame_active |=> phase_reg == PH_HI && lnk.tx_byte == read_word_reg[15:8])
      else $error("high data byte not offered");

   a_over_zero: assert property (@(posedge clk) disable iff (!nrst) // [RULE9]
      phase_reg == PH_OVER |-> lnk.tx_byte == BYTE_ZERO) else $error("extra byte not zero");

   a_read_inert: assert property (@(posedge clk) disable iff (!nrst)
      lo_done && !write_req_reg |=> !start_cal_reg && !store_cal_reg) else $error("read changed command"); // [RULE11]

   a_upper_zero: assert property (@(posedge clk) disable iff (!nrst)
      sel_done && sel_index == IDX_COMMAND |=> read_word_reg[15:8] == BYTE_ZERO)
      else $error("command upper byte not zero"); // [RULE12]

   a_cal_start: assert property (@(posedge clk) disable iff (!nrst)
      set_start |=> start_flag_reg && start_cal_reg ##1 !start_cal_reg) else $error("calibration not started"); // [RULE14]

   a_cal_clear: assert property (@(posedge clk) disable iff (!nrst)
      cal_done && !set_start |=> !start_flag_reg) else $error("calibration flag not cleared"); // [RULE14]

   a_cal_fail: assert property (@(posedge clk) disable iff (!nrst)
      cal_done |=> fail_flag_reg == !$past(cal_ok)) else $error("fail flag wrong"); // [RULE15]

   a_store_cycle: assert property (@(posedge clk) disable iff (!nrst)
      store_done && !set_store |=> !store_flag_reg) else $error("store flag not cleared"); // [RULE16]

   a_invalid_fill: assert property (@(posedge clk) disable iff (!nrst)
      sel_done && sel_index == IDX_OXYGEN && !readings_valid |=> read_word_reg == OXYGEN_INVALID)
      else $error("invalid oxygen not substituted"); // [RULE20]

   a_frame_restart: assert property (@(posedge clk) disable iff (!nrst)
      !lnk.frame_active |=> phase_reg == PH_IDLE) else $error("phase not reset on deselect"); // [RULE25]

   a_full_byte: assert property (@(posedge clk) disable iff (!nrst)
      start_cal_reg || store_cal_reg |-> $past(lnk.byte_done) && $past(phase_reg) == PH_LO)
      else $error("write without complete byte"); // [RULE26]

   a_store_start: assert property (@(posedge clk) disable iff (!nrst) // [RULE16]
      set_store |=> store_flag_reg && store_cal_reg) else $error("store not started");

   a_lambda_fill: assert property (@(posedge clk) disable iff (!nrst) // [RULE20]
      sel_done && sel_index == IDX_LAMBDA && !readings_valid |=> read_word_reg == LAMBDA_INVALID)
      else $error("invalid lambda not substituted");

   a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst) // [RULE8]
      sel_done && sel_index > IDX_LAMBDA |=> read_word_reg == UNMAPPED_WORD)
      else $error("unmapped word not zero");

   a_cmd_snapshot: assert property (@(posedge clk) disable iff (!nrst) // [RULE15]
      sel_done && sel_index == IDX_COMMAND |=> read_word_reg[BIT_START_CAL] == $past(start_flag_reg)
      && read_word_reg[BIT_CAL_FAILED] == $past(fail_flag_reg)) else $error("command flags not reported");

   a_write_target: assert property (@(posedge clk) disable iff (!nrst) // [RULE8]
      lo_done && write_req_reg && word_idx_reg != IDX_COMMAND |=> !start_cal_reg && !store_cal_reg)
      else $error("read-only word written");
endmodule

/* File: design/o2_pkg.sv */
// Purpose: Shared types and constants of the oxygen sensor serial slave
// Assumes: One 200 MHz system clock, power-on reset
// Notes:   Error codes, word indices and command bit positions live here
package o2_pkg;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef logic [7:0] byte_t;
   typedef logic [15:0] word_t;
   typedef logic [6:0] index_t;
   typedef enum logic [4:0] {
      PH_IDLE = 5'b00001,
      PH_SEL  = 5'b00010,
      PH_LO   = 5'b00100,
      PH_HI   = 5'b01000,
      PH_OVER = 5'b10000
   } frame_phase_t;

   // ---------------------------------------------------------------
   // Word indices and command fields
   // ---------------------------------------------------------------
   localparam index_t IDX_COMMAND = 7'h00;
   localparam index_t IDX_OXYGEN = 7'h01;
   localparam index_t IDX_LAMBDA = 7'h02;
   localparam int BIT_WRITE_REQ = 7;
   localparam int BIT_START_CAL = 0;
   localparam int BIT_STORE_CAL = 3;
   localparam int BIT_CAL_FAILED = 5;
   localparam byte_t BYTE_ZERO = 8'h00;
   localparam word_t COMMAND_RESET = 16'h0000;
   localparam word_t UNMAPPED_WORD = 16'h0000;
   localparam word_t OXYGEN_INVALID = 16'h8000;
   localparam word_t LAMBDA_INVALID = 16'h0000;

   // ---------------------------------------------------------------
   // Error codes
   // ---------------------------------------------------------------
   localparam byte_t EC_NORMAL = 8'h00;
   localparam byte_t EC_INIT = 8'h01;
   localparam byte_t EC_HEATER_OPEN = 8'h14;
   localparam byte_t EC_HEATER_SHORT = 8'h15;
   localparam byte_t EC_SUPPLY_LOW = 8'h31;
   localparam byte_t EC_SUPPLY_HIGH = 8'h32;
   localparam byte_t EC_WARMUP_A = 8'h41;
   localparam byte_t EC_WARMUP_B = 8'h51;
   localparam byte_t EC_LOW_ENERGY = 8'h52;

   // ---------------------------------------------------------------
   // Timing and pin reset values
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int SCLK_MAX_HZ = 1_820_000;
   localparam int SCLK_HALF_CYCLES = (CLK_HZ / SCLK_MAX_HZ) / 2;
   localparam logic [2:0] PINS_IDLE = 3'h4;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // [RULE18] [RULE19] Faults invalid, supply warnings valid
   function automatic logic readings_ok(input byte_t ec);
      return (ec == EC_NORMAL) || (ec == EC_SUPPLY_LOW) || (ec == EC_SUPPLY_HIGH);
   endfunction
endpackage

/* File: design/link_if.sv */
// Purpose: Byte-level carrier between serial front end and word logic
// Assumes: Both ends on clk
// Notes:   byte_done is a one-cycle pulse with rx_byte valid beside it
`timescale 1ns/1ps
interface link_if;
   logic byte_done;
   logic [7:0] rx_byte;
   logic frame_active;
   logic [7:0] tx_byte;
   modport front (output byte_done, output rx_byte, output frame_active, input tx_byte);
   modport core (input byte_done, input rx_byte, input frame_active, output tx_byte);
endinterface

/* File: design/spi_link_frontend.sv */
// Purpose: Mode 0 serial shifter, pins sampled by clk
// Assumes: Serial clock far slower than clk
// Notes:   Each pin passes three flops; a change counts once flops 2 and 3 agree
`timescale 1ns/1ps
module spi_link_frontend (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe_n,
   link_if.front lnk
);
   import o2_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchronisers, order {cs_n, sclk, mosi}
   // ---------------------------------------------------------------
   logic [2:0] s1_reg, s2_reg, s3_reg, filt_reg;
   wire [2:0] filt_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);
   wire sclk_rise = filt_next[1] & ~filt_reg[1];
   wire sclk_fall = ~filt_next[1] & filt_reg[1];
   wire cs_fall = ~filt_next[2] & filt_reg[2];
   wire in_frame = ~filt_next[2] & ~filt_reg[2];

   logic [2:0] bit_cnt_reg;
   byte_t rx_sh_reg, tx_sh_reg, rx_byte_reg;
   logic miso_reg, oe_n_reg, done_reg;
   // [RULE2] Shift in MSB first
   wire byte_t rx_next = {rx_sh_reg[6:0], filt_next[0]};
   wire last_bit = (bit_cnt_reg == BIT_LAST);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= PINS_IDLE;
         s2_reg <= PINS_IDLE;
         s3_reg <= PINS_IDLE;
         filt_reg <= PINS_IDLE;
      end else begin
         s1_reg <= {cs_n, sclk, mosi};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   // ---------------------------------------------------------------
   // Shifter
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bit_cnt_reg <= 3'h0;
         rx_sh_reg <= BYTE_ZERO;
         tx_sh_reg <= BYTE_ZERO;
         rx_byte_reg <= BYTE_ZERO;
         miso_reg <= 1'b0;
         oe_n_reg <= 1'b1;
         done_reg <= 1'b0;
      end else begin
         done_reg <= in_frame & sclk_rise & last_bit;
         if (cs_fall) begin
            bit_cnt_reg <= 3'h0;
            tx_sh_reg <= lnk.tx_byte;
            miso_reg <= lnk.tx_byte[7];
            oe_n_reg <= 1'b0;
         end else if (!in_frame) begin
            bit_cnt_reg <= 3'h0;
            miso_reg <= 1'b0;
            oe_n_reg <= 1'b1;
         end else begin
            // [RULE1] Sample on rising edge
            if (sclk_rise) begin
               rx_sh_reg <= rx_next;
               bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
               if (last_bit) begin
                  rx_byte_reg <= rx_next;
               end
            end
            // [RULE1] Change on falling edge
            if (sclk_fall) begin
               if (bit_cnt_reg == 3'h0) begin
                  tx_sh_reg <= lnk.tx_byte;
                  miso_reg <= lnk.tx_byte[7];
               end else begin
                  tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                  miso_reg <= tx_sh_reg[6];
               end
            end
         end
      end
   end

   assign miso = miso_reg;
   assign miso_oe_n = oe_n_reg;
   assign lnk.byte_done = done_reg;
   assign lnk.rx_byte = rx_byte_reg;
   assign lnk.frame_active = ~filt_reg[2];

   a_miso_release: assert property (@(posedge clk) disable iff (!nrst)
      filt_reg[2] && filt_next[2] |=> oe_n_reg) else $error("miso driven while deselected"); // [RULE25]
endmodule

/* File: design/standby_valid_ctrl.sv */
// Purpose: Valid output, heater enable and analog zero from standby pin
// Assumes: Error code comes from logic on clk
// Notes:   Standby pin passes three flops
`timescale 1ns/1ps
module standby_valid_ctrl (
   input wire logic clk,
   input wire logic nrst,
   input wire logic standby_n,
   input wire o2_pkg::byte_t error_code_byte,
   output logic valid,
   output logic heater_on,
   output logic analog_zero
);
   import o2_pkg::*;

   logic s1_reg, s2_reg, s3_reg, run_reg;
   logic valid_reg, heater_reg, zero_reg;
   wire run_next = (s2_reg == s3_reg) ? s3_reg : run_reg;
   wire valid_next = run_next & readings_ok(error_code_byte);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         run_reg <= 1'b0;
         valid_reg <= 1'b0;
         heater_reg <= 1'b0;
         zero_reg <= 1'b1;
      end else begin
         s1_reg <= standby_n;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         run_reg <= run_next;
         // [RULE21] Valid once ready
         valid_reg <= valid_next;
         // [RULE22] Standby forces outputs
         heater_reg <= run_next;
         zero_reg <= ~valid_next;
      end
   end

   assign valid = valid_reg;
   assign heater_on = heater_reg;
   assign analog_zero = zero_reg;

   a_standby_off: assert property (@(posedge clk) disable iff (!nrst)
      !run_next |=> !valid_reg && !heater_reg && zero_reg) else $error("standby not honoured"); // [RULE22]
   a_valid_ready: assert property (@(posedge clk) disable iff (!nrst)
      run_next && readings_ok(error_code_byte) |=> valid_reg) else $error("valid not raised"); // [RULE21]
endmodule

/* File: verification/spi_host_model.sv */
// Purpose: Mode 0 serial master standing in for the host controller
// Assumes: Driven just after clk edges; halves counted in clk cycles
// Notes:   A released data line reads as the inverse of its last level
`timescale 1ns/1ps
module spi_host_model #(parameter int HALF = 55) (
   input wire logic clk,
   input wire logic miso,
   input wire logic miso_oe_n,
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   logic last;
   logic line;
   assign line = (miso_oe_n === 1'b0) ? miso : ~last;
   always @(posedge clk) begin
      if (miso_oe_n === 1'b0) last <= miso;
   end
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      last = 1'b0;
   end
   task automatic wait_half();
      repeat (HALF) @(posedge clk);
      #1;
   endtask
   // Framed, msb first, sample on rise
   task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
      rx = 24'h000000;
      cs_n = 1'b0;
      wait_half();
      for (int i = 0; i < nbits; i++) begin
         mosi = tx[23 - i];
         wait_half();
         sclk = 1'b1;
         rx[23 - i] = line;
         wait_half();
         sclk = 1'b0;
      end
      wait_half();
      cs_n = 1'b1;
      mosi = ~mosi;
      wait_half();
   endtask
endmodule

/* File: verification/o2_spi_slave_tb_top.sv */
// Purpose: Self-checking bench of the oxygen sensor serial slave
// Assumes: Host model frames every transfer; core inputs driven here
// Notes:   Expected words come from the code table below
`timescale 1ns/1ps
module o2_spi_slave_tb_top;
   import o2_pkg::*;
   logic clk, nrst, sclk, cs_n, mosi, miso, miso_oe_n, standby_n;
   byte_t error_code_byte;
   word_t oxygen_raw, lambda_raw;
   logic cal_done, cal_ok, store_done, start_cal, store_cal, valid, heater_on, analog_zero;
   int fail_count = 0;
   int comparisons = 0;
   int cal_pulses = 0;
   int store_pulses = 0;
   byte_t ec;
   word_t w;
   logic [23:0] junk;
   byte_t codes [9] = '{8'h00, 8'h01, 8'h14, 8'h15, 8'h31, 8'h32, 8'h41, 8'h51, 8'h52};
   logic ok_tab [9] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
   o2_spi_slave i_dut (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .miso_oe_n(miso_oe_n), .standby_n(standby_n), .error_code_byte(error_code_byte),
      .oxygen_raw(oxygen_raw), .lambda_raw(lambda_raw), .cal_done(cal_done), .cal_ok(cal_ok),
      .store_done(store_done), .start_cal(start_cal), .store_cal(store_cal), .valid(valid),
      .heater_on(heater_on), .analog_zero(analog_zero));
   spi_host_model #(.HALF(55)) i_host (.clk(clk), .miso(miso), .miso_oe_n(miso_oe_n), .sclk(sclk),
      .cs_n(cs_n), .mosi(mosi));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (start_cal === 1'b1) cal_pulses++;
      if (store_cal === 1'b1) store_pulses++;
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] sel, input logic [15:0] dummy, output byte_t e, output word_t d);
      logic [23:0] rx;
      i_host.xfer({sel, dummy}, 24, rx);
      e = rx[23:16];
      d = {rx[7:0], rx[15:8]};
   endtask
   // Returned bytes dropped, reserved bits zero
   task automatic wr(input index_t idx, input word_t d);
      logic [23:0] rx;
      i_host.xfer({1'b1, idx, d[7:0], d[15:8]}, 24, rx);
   endtask
   task automatic pulse_cal(input logic ok);
      cal_ok = ok;
      cal_done = 1'b1;
      tick(1);
      cal_done = 1'b0;
      tick(2);
   endtask
   task automatic results();
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #450000;
      fail_count++;
      results();
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      standby_n = 1'b1;
      error_code_byte = 8'h01;
      oxygen_raw = 16'hfc18;
      lambda_raw = 16'h03e8;
      cal_done = 1'b0;
      cal_ok = 1'b0;
      store_done = 1'b0;
      tick(8);
      nrst = 1'b1;
      tick(10);
      check(valid, 1'b0);
      check(analog_zero, 1'b1);
      check({miso, miso_oe_n}, 2'b01);
      rd(8'h00, 16'h0000, ec, w);
      check(ec, 8'h01);
      check(w, 16'h0000);
      check({miso, miso_oe_n}, 2'b01);
      $display("test reset done");
      // Poll valid, then read the error code
      // Reads packed close; no shared resource behind this model
      for (int i = 0; i < 9; i++) begin
         error_code_byte = codes[i];
         tick(8);
         check(valid, ok_tab[i]);
         rd((i % 2 == 0) ? 8'h01 : 8'h02, 16'ha5c3, ec, w);
         check(ec, codes[i]);
         if (i % 2 == 0) check(w, ok_tab[i] ? 16'hfc18 : 16'h8000);
         else check(w, ok_tab[i] ? 16'h03e8 : 16'h0000);
      end
      error_code_byte = 8'h00;
      $display("test codes done");
      wr(7'h01, 16'h1234);
      rd(8'h01, 16'h0000, ec, w);
      check(w, 16'hfc18);
      rd(8'h05, 16'h0000, ec, w);
      check(w, 16'h0000);
      $display("test access done");
      wr(7'h00, 16'h0001);
      check(16'(cal_pulses), 16'h0001);
      rd(8'h00, 16'hffff, ec, w);
      check(w, 16'h0001);
      check(16'(cal_pulses), 16'h0001);
      rd(8'h00, 16'h0000, ec, w);
      check(w, 16'h0001);
      pulse_cal(1'b0);
      rd(8'h00, 16'h0000, ec, w);
      check(w, 16'h0020);
      wr(7'h00, 16'h0001);
      pulse_cal(1'b1);
      rd(8'h00, 16'h0000, ec, w);
      check(w, 16'h0000);
      wr(7'h00, 16'h0008);
      check(16'(store_pulses), 16'h0001);
      rd(8'h00, 16'h0000, ec, w);
      check(w, 16'h0008);
      store_done = 1'b1;
      tick(1);
      store_done = 1'b0;
      tick(2);
      rd(8'h00, 16'h0000, ec, w);
      check(w, 16'h0000);
      i_host.xfer(24'h800100, 12, junk);
      check(16'(cal_pulses), 16'h0002);
      rd(8'h00, 16'h0000, ec, w);
      check(ec, 8'h00);
      check(w, 16'h0000);
      $display("test command done");
      standby_n = 1'b0;
      tick(10);
      check({valid, heater_on, analog_zero}, 3'b001);
      standby_n = 1'b1;
      tick(10);
      check({valid, heater_on, analog_zero}, 3'b110);
      $display("test standby done");
      results();
   end
endmodule
